// ---- psmc_defs.vh ----
`ifndef PSMC_DEFS_VH
`define PSMC_DEFS_VH

// wishbone register byte offsets
`define PSMC_ADDR_W 8
`define PSMC_OFF_POWER_CONTROL_REG 8'h00
`define PSMC_OFF_STAT 8'h04

// power control register bit positions
`define PSMC_BIT_IDLE_EN 0
`define PSMC_BIT_IDLE_SET 1
`define PSMC_BIT_PD_EN 2
`define PSMC_BIT_PD_SET 3
`define PSMC_BIT_SLOW 4
`define PSMC_POWER_CONTROL_REG_RST 8'h00

// status register bit positions
`define PSMC_ST_SLOW 0
`define PSMC_ST_IDLE 1
`define PSMC_ST_SWPD 2
`define PSMC_ST_HW_POWERDOWN_N 3
`define PSMC_ST_SWEN 4
`define PSMC_ST_WDT 5
`define PSMC_ST_RSTSEQ 6

// slow-down divide ratio and machine cycle length
`define PSMC_SLOW_DIV 3'h7
`define PSMC_MCYC 4'hb
// last machine cycle count of the internal reset sequence, which spans three machine cycles
`define PSMC_RST_MCYC 4'h2

`endif

// ---- psmc_clkdiv.v ----
// divider producing clock-enable ticks for slow-down and machine cycles
module psmc_clkdiv (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire slow_i,
  output reg tick_o,
  output reg mcyc_o
);
`include "psmc_defs.vh"

  reg [2:0] div_reg;
  reg [3:0] mc_reg;
  wire pre;

  // divide by eight when slowed, otherwise every clock
  assign pre = run_i & (~slow_i | (div_reg == `PSMC_SLOW_DIV));

  // prescale and machine cycle counters
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 3'h0;
      mc_reg <= 4'h0;
      tick_o <= 1'b0;
      mcyc_o <= 1'b0;
    end else begin
      div_reg <= run_i ? div_reg + 3'h1 : 3'h0;
      tick_o <= pre;
      mcyc_o <= 1'b0;
      if (pre) begin
        if (mc_reg == `PSMC_MCYC) begin
          mc_reg <= 4'h0;
          mcyc_o <= 1'b1;
        end else begin
          mc_reg <= mc_reg + 4'h1;
        end
      end
    end
  end

endmodule

// ---- psmc_top.v ----
module psmc_top (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire cyc_i,
  input wire stb_i,
  input wire hw_powerdown_n_i,
  input wire powersave_enable_wdt_autostart_n_i,
  input wire wake_irq_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg cpu_clk_en_o,
  output reg periph_clk_en_o,
  output reg osc_en_o,
  output reg rc_osc_en_o,
  output reg port_oe_o,
  output reg int_reset_o,
  output reg wdt_autostart_o,
  output reg [1:0] mode_o
);
`include "psmc_defs.vh"

  // mode codes
  localparam M_NORMAL = 2'h0;
  localparam M_IDLE = 2'h1;
  localparam M_SWPD = 2'h2;
  localparam M_HW_POWERDOWN_N = 2'h3;

  // hardware power-down sequence states
  localparam H_RUN = 2'h0;
  localparam H_RESET = 2'h1;
  localparam H_DOWN = 2'h2;

  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg [1:0] hst_reg;
  reg [1:0] hst_next;
  reg [3:0] rcnt_reg;
  reg [3:0] rcnt_next;
  reg slow_reg;
  reg slow_next;
  reg idle_en_reg;
  reg idle_en_next;
  reg pd_en_reg;
  reg pd_en_next;
  reg wdt_reg;
  reg wdt_next;
  reg hw_powerdown_n_seen_reg;
  reg bus_wr_prev_reg;
  wire sw_blocked;
  wire bus_req;
  wire wr_power_control_reg;
  wire [7:0] wdata;
  wire tick;
  wire mcyc;
  wire running;
  wire [7:0] power_control_reg_view;
  wire [7:0] stat_view;

  // an open pin is seen high by the pad pull-up
  assign sw_blocked = powersave_enable_wdt_autostart_n_i;

  // classic wishbone single access, ack one cycle after strobe
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_power_control_reg = bus_req & we_i & sel_i[0] & (adr_i == `PSMC_OFF_POWER_CONTROL_REG);
  assign wdata = dat_i[7:0];
  assign running = (hst_reg == H_RUN) & (mode_reg != M_SWPD);

  // the machine cycle timebase follows the slow-down setting
  psmc_clkdiv u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(running | (hst_reg == H_RESET)),
    .slow_i(slow_reg),
    .tick_o(tick),
    .mcyc_o(mcyc)
  );

  assign power_control_reg_view = {3'h0, slow_reg, 1'b0, pd_en_reg, 1'b0, idle_en_reg};
  assign stat_view = {1'b0, hst_reg == H_RESET, wdt_reg,
                      ~sw_blocked, mode_reg == M_HW_POWERDOWN_N,
                      mode_reg == M_SWPD, mode_reg == M_IDLE, slow_reg};

  // pin sampled once per machine cycle while running, every clock in the reset and down states
  always @(posedge clk_i) begin
    if (rst_i) begin
      hw_powerdown_n_seen_reg <= 1'b0;
    end else if (mcyc | (hst_reg != H_RUN)) begin
      hw_powerdown_n_seen_reg <= ~hw_powerdown_n_i;
    end
  end

  // mode and hardware power-down sequencing
  always @* begin
    mode_next = mode_reg;
    hst_next = hst_reg;
    rcnt_next = rcnt_reg;
    slow_next = slow_reg;
    idle_en_next = 1'b0;
    pd_en_next = 1'b0;
    wdt_next = wdt_reg;
    case (hst_reg)
      H_RUN: begin
        // hardware request wins regardless of enable pin
        if (hw_powerdown_n_seen_reg) begin
          hst_next = H_RESET;
          rcnt_next = 4'h0;
        end else if (mode_reg == M_SWPD) begin
          // only a hardware reset leaves power-down
          mode_next = M_SWPD;
        end else begin
          if (mode_reg == M_IDLE && wake_irq_i) begin
            mode_next = M_NORMAL;
          end
          // enable bits last for one following write only
          if (wr_power_control_reg && !sw_blocked) begin
            slow_next = wdata[`PSMC_BIT_SLOW];
            idle_en_next = wdata[`PSMC_BIT_IDLE_EN] &
                           ~wdata[`PSMC_BIT_IDLE_SET];
            pd_en_next = wdata[`PSMC_BIT_PD_EN] &
                         ~wdata[`PSMC_BIT_PD_SET];
            if (pd_en_reg && wdata[`PSMC_BIT_PD_SET]) begin
              mode_next = M_SWPD;
              slow_next = slow_reg;
            end else if (idle_en_reg && wdata[`PSMC_BIT_IDLE_SET]) begin
              mode_next = M_IDLE;
            end
          end else if (bus_req && !sw_blocked) begin
            // any other access breaks the two-step sequence
            idle_en_next = 1'b0;
            pd_en_next = 1'b0;
          end else if (!bus_req) begin
            idle_en_next = idle_en_reg;
            pd_en_next = pd_en_reg;
          end
        end
      end
      H_RESET: begin
        // full internal reset before oscillators stop
        mode_next = M_NORMAL;
        slow_next = 1'b0;
        wdt_next = 1'b0;
        if (mcyc) begin
          rcnt_next = rcnt_reg + 4'h1;
          if (rcnt_reg == `PSMC_RST_MCYC) begin
            hst_next = H_DOWN;
            mode_next = M_HW_POWERDOWN_N;
          end
        end
      end
      H_DOWN: begin
        // held while low, straight back to run on release without another reset
        if (!hw_powerdown_n_seen_reg) begin
          hst_next = H_RUN;
          mode_next = M_NORMAL;
          wdt_next = sw_blocked;
        end
      end
      default: begin
        hst_next = H_RUN;
        mode_next = M_NORMAL;
      end
    endcase
  end

  // state registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= M_NORMAL;
      hst_reg <= H_RUN;
      rcnt_reg <= 4'h0;
      slow_reg <= 1'b0;
      idle_en_reg <= 1'b0;
      pd_en_reg <= 1'b0;
      wdt_reg <= 1'b0;
      bus_wr_prev_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      hst_reg <= hst_next;
      rcnt_reg <= rcnt_next;
      slow_reg <= slow_next;
      idle_en_reg <= idle_en_next;
      pd_en_reg <= pd_en_next;
      // watchdog start taken from the pin in the first cycle after reset, again on leaving hardware power-down
      wdt_reg <= bus_wr_prev_reg ? wdt_next : sw_blocked;
      bus_wr_prev_reg <= 1'b1;
    end
  end

  // clock enables, oscillators and pad control
  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      osc_en_o <= 1'b1;
      rc_osc_en_o <= 1'b1;
      port_oe_o <= 1'b1;
      int_reset_o <= 1'b1;
      wdt_autostart_o <= 1'b0;
      mode_o <= M_NORMAL;
    end else begin
      cpu_clk_en_o <= tick & (mode_next == M_NORMAL) &
                      (hst_next == H_RUN);
      periph_clk_en_o <= tick & (mode_next != M_SWPD) &
                         (hst_next == H_RUN);
      osc_en_o <= (mode_next != M_SWPD) & (hst_next != H_DOWN);
      rc_osc_en_o <= (mode_next != M_SWPD) &
                     (hst_next != H_DOWN);
      port_oe_o <= (hst_next != H_DOWN);
      int_reset_o <= (hst_next != H_RUN);
      wdt_autostart_o <= wdt_reg;
      mode_o <= mode_next;
    end
  end

  // wishbone read data and ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        case (adr_i)
          `PSMC_OFF_POWER_CONTROL_REG: dat_o <= {24'h000000, power_control_reg_view};
          `PSMC_OFF_STAT: dat_o <= {24'h000000, stat_view};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ---- psmc_props.sv ----
module psmc_props (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire hw_powerdown_n_i,
  input wire cpu_clk_en_o,
  input wire osc_en_o,
  input wire rc_osc_en_o,
  input wire port_oe_o,
  input wire int_reset_o,
  input wire wdt_autostart_o,
  input wire [1:0] mode_o
);
  // one clock domain, checks off in reset
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // bus handshake
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  // clocks and pads per mode
  chk_idle_gate: assert property (
    mode_o == 2'h1 |-> !cpu_clk_en_o) else $error("cpu clocked in idle");
  chk_swpd_osc: assert property (
    mode_o == 2'h2 |-> !osc_en_o && !rc_osc_en_o) else $error("osc on");
  chk_hw_powerdown_n_float: assert property (
    mode_o == 2'h3 |-> !port_oe_o && !osc_en_o) else $error("pads driven");
  chk_hw_powerdown_n_seq: assert property (
    $fell(hw_powerdown_n_i) |-> ##[1:100] int_reset_o) else $error("no reset");
  chk_hw_powerdown_n_exit: assert property (
    mode_o == 2'h3 && hw_powerdown_n_i |-> ##[1:13] mode_o != 2'h3)
    else $error("stuck down");
  chk_wdt_hold: assert property (
    (!int_reset_o)[*4] |-> $stable(wdt_autostart_o)) else $error("wdt moved");
endmodule
bind psmc_top psmc_props psmc_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .mode_o(mode_o),
  .hw_powerdown_n_i(hw_powerdown_n_i), .cpu_clk_en_o(cpu_clk_en_o),
  .osc_en_o(osc_en_o), .rc_osc_en_o(rc_osc_en_o), .port_oe_o(port_oe_o),
  .int_reset_o(int_reset_o), .wdt_autostart_o(wdt_autostart_o));

// ---- psmc_board.sv ----
module psmc_board (
  input wire pd_req_i,
  input wire en_req_i,
  input wire open_i,
  output wire hw_pin_n_o,
  output wire en_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins follow bench commands; an open enable pin is pulled high
  assign hw_pin_n_o = ~pd_req_i;
  assign en_pin_n_o = open_i | en_req_i;
endmodule

// ---- psmc_top_tb.sv ----
`include "psmc_defs.vh"
module psmc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // open enable pin, two control writes, mode left
  typedef struct packed {logic en; logic [7:0] a, b;
    logic [1:0] m;} psmc_row_t;
  psmc_row_t rows[6] = '{{1'h1, 8'h04, 8'h08, 2'h0},
    {1'h1, 8'h01, 8'h02, 2'h0}, {1'h0, 8'h01, 8'h02, 2'h1},
    {1'h0, 8'h04, 8'h08, 2'h2}, {1'h0, 8'h0c, 8'h08, 2'h0},
    {1'h0, 8'h02, 8'h01, 2'h0}};
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
  logic we_i = 1'h0, pd_req = 1'h0, en_req = 1'h0, open_pin = 1'h0;
  logic wake = 1'h0;
  wire periph_clk_en_o;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, rd;
  wire [31:0] dat_o;
  wire [1:0] mode_o;
  wire ack_o, cpu_clk_en_o, osc_en_o, rc_osc_en_o, port_oe_o;
  wire int_reset_o, wdt_autostart_o, hw_pin_n, en_pin_n;
  int fail_count = 0, cmp_count = 0, cnt;
  // board pins and the design
  psmc_board psmc_board_i (.pd_req_i(pd_req), .en_req_i(en_req),
    .open_i(open_pin), .hw_pin_n_o(hw_pin_n), .en_pin_n_o(en_pin_n));
  psmc_top psmc_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .we_i(we_i), .sel_i(4'h1), .cyc_i(cyc_i),
    .stb_i(stb_i), .hw_powerdown_n_i(hw_pin_n), .wake_irq_i(wake),
    .powersave_enable_wdt_autostart_n_i(en_pin_n), .dat_o(dat_o),
    .ack_o(ack_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o),
    .osc_en_o(osc_en_o), .rc_osc_en_o(rc_osc_en_o), .port_oe_o(port_oe_o),
    .int_reset_o(int_reset_o), .wdt_autostart_o(wdt_autostart_o),
    .mode_o(mode_o));
  // 50 mhz clock
  always #10 clk_i = ~clk_i;
  // compare and count
  task check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // counts, verdict, end
  task finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // two-cycle reset
  task do_reset();
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // one bus cycle held until ack, then one idle cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    {cyc_i, stb_i} <= 2'h3;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (n = 0; n < 20 && ack_o !== 1'h1; n++) @(posedge clk_i);
    check("ack", 32'(n < 20), 32'h1);
    if (n == 20) finish_test();
    rd = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  // bounded wait for a mode
  task wait_mode(input logic [1:0] m);
    int n;
    for (n = 0; n < 200 && mode_o !== m; n++) @(posedge clk_i);
    check("mode", 32'(mode_o), 32'(m));
    if (n == 200) finish_test();
  endtask
  // table rows, then pin change, hardware power-down, idle, slow-down
  initial begin
    foreach (rows[i]) begin
      open_pin <= rows[i].en;
      do_reset();
      wb(1'h1, `PSMC_OFF_POWER_CONTROL_REG, {24'h0, rows[i].a});
      wb(1'h1, `PSMC_OFF_POWER_CONTROL_REG, {24'h0, rows[i].b});
      check("mode", 32'(mode_o), 32'(rows[i].m));
      check("osc", 32'(osc_en_o), 32'(rows[i].m != 2'h2));
      check("wdt", 32'(wdt_autostart_o), 32'(rows[i].en));
      $display("row %0d done", i);
    end
    en_req <= 1'h1;
    repeat (4) @(posedge clk_i);
    check("wdt", 32'(wdt_autostart_o), 32'h0);
    pd_req <= 1'h1;
    wait_mode(2'h3);
    check("pads", 32'(port_oe_o), 32'h0);
    check("osc", 32'({osc_en_o, rc_osc_en_o}), 32'h0);
    pd_req <= 1'h0;
    wait_mode(2'h0);
    check("pads", 32'(port_oe_o), 32'h1);
    $display("hardware power-down done");
    en_req <= 1'h0;
    do_reset();
    // idle entry, peripherals still clocked, wake by interrupt
    wb(1'h1, `PSMC_OFF_POWER_CONTROL_REG, 32'h01);
    wb(1'h1, `PSMC_OFF_POWER_CONTROL_REG, 32'h02);
    check("mode", 32'(mode_o), 32'h1);
    check("cpu", 32'(cpu_clk_en_o), 32'h0);
    check("periph", 32'(periph_clk_en_o), 32'h1);
    wake <= 1'h1;
    wait_mode(2'h0);
    wake <= 1'h0;
    @(posedge clk_i);
    $display("idle done");
    wb(1'h1, `PSMC_OFF_POWER_CONTROL_REG, 32'h10);
    repeat (30) @(posedge clk_i);
    cnt = 0;
    repeat (80) begin
      @(posedge clk_i);
      cnt += cpu_clk_en_o;
    end
    check("slow", 32'(cnt), 32'h0a);
    wb(1'h0, `PSMC_OFF_STAT, 32'h0);
    check("stat", rd, (32'h1 << `PSMC_ST_SLOW) |
      (32'h1 << `PSMC_ST_SWEN));
    wb(1'h0, 8'h08, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("slow-down done");
    finish_test();
  end
endmodule
